// ==== rtl/dis_pkg.sv ====
/*
  Shared constants for the dac interrupt status and link check block:
  register offsets, bit positions, flag indices, reset values.
  Assumes an 8-bit register port with 12-bit byte addresses.
*/
package dis_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int FLAG_N = 8;

  // register offsets
  localparam logic [11:0] OFS_DAC0_LATCH_EN = 12'h021;
  localparam logic [11:0] OFS_DAC1_LATCH_EN = 12'h022;
  localparam logic [11:0] OFS_DAC0_STATUS = 12'h025;
  localparam logic [11:0] OFS_DAC1_STATUS = 12'h026;
  localparam logic [11:0] OFS_LIVE_COND = 12'h027;
  localparam logic [11:0] OFS_PENDING = 12'h028;
  localparam logic [11:0] OFS_CHECKS = 12'h030;
  localparam logic [11:0] OFS_CONV_LANES = 12'h031;
  localparam logic [11:0] OFS_SAMPLES_OCTETS = 12'h032;
  localparam logic [11:0] OFS_FRAMES_PER_MF = 12'h033;
  localparam logic [11:0] OFS_MF_CLOCK_DELAY = 12'h035;
  localparam logic [11:0] OFS_WINDOW_LIMIT = 12'h036;

  // flag index inside the internal flag vector
  localparam int FLG_DAC0_TRIP = 0;
  localparam int FLG_DAC0_WINDOW = 1;
  localparam int FLG_DAC1_TRIP = 2;
  localparam int FLG_DAC1_WINDOW = 3;
  localparam int FLG_DAC1_ROTATE = 4;
  localparam int FLG_DAC1_LOCK = 5;
  localparam int FLG_DAC1_BLANK = 6;
  localparam int FLG_DAC1_POWER = 7;

  // bit positions in the dac0 and dac1 status / latch enable registers
  localparam int D0_TRIP_BIT = 0;
  localparam int D0_WINDOW_BIT = 1;
  localparam int D1_TRIP_BIT = 0;
  localparam int D1_WINDOW_BIT = 1;
  localparam int D1_ROTATE_BIT = 2;
  localparam int D1_LOCK_BIT = 3;
  localparam int D1_BLANK_BIT = 5;
  localparam int D1_POWER_BIT = 7;

  // bit positions in the check register
  localparam int CHK_K_BIT = 2;
  localparam int CHK_COMBO_BIT = 3;
  localparam int CHK_WINDOW_BIT = 4;
  localparam int CHK_DELAY_BIT = 5;

  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_LATCH_EN = 8'h00;
  localparam logic [3:0] RST_CONV_COUNT = 4'h2;
  localparam logic [3:0] RST_LANE_COUNT = 4'h4;
  localparam logic [3:0] RST_SAMPLES = 4'h1;
  localparam logic [3:0] RST_OCTETS = 4'h1;
  localparam logic [7:0] RST_FRAMES_PER_MF = 8'h20;
  localparam logic [7:0] RST_MF_CLOCK_DELAY = 8'h00;
  localparam logic [7:0] RST_WINDOW_LIMIT = 8'h00;

  // supported link settings
  localparam logic [7:0] K_SUPPORTED_A = 8'h10;
  localparam logic [7:0] K_SUPPORTED_B = 8'h20;
  localparam logic [7:0] WINDOW_LIMIT_MAX = 8'h03;
endpackage

// ==== rtl/dis_chk_if.sv ====
/*
  Carries link configuration from the register file to the checker and
  the check results back. Both ends run on the one register clock.
*/
`timescale 1ns/1ps
interface dis_chk_if;
  logic [3:0] conv_count;
  logic [3:0] lane_count;
  logic [3:0] samples_per_frame;
  logic [3:0] octets_per_frame;
  logic [7:0] frames_per_multiframe;
  logic [7:0] multiframe_clock_delay;
  logic [7:0] window_limit;
  logic delay_exceeds_multiframe;
  logic window_limit_unsupported;
  logic lane_combo_unsupported;
  logic frames_per_multiframe_unsupported;

  modport cfg (
    output conv_count, lane_count, samples_per_frame, octets_per_frame,
    output frames_per_multiframe, multiframe_clock_delay, window_limit,
    input delay_exceeds_multiframe, window_limit_unsupported,
    input lane_combo_unsupported, frames_per_multiframe_unsupported
  );
  modport chk (
    input conv_count, lane_count, samples_per_frame, octets_per_frame,
    input frames_per_multiframe, multiframe_clock_delay, window_limit,
    output delay_exceeds_multiframe, window_limit_unsupported,
    output lane_combo_unsupported, frames_per_multiframe_unsupported
  );
endinterface // dis_chk_if

// ==== rtl/dis_flag_cell.sv ====
/*
  One status flag: mirrors its condition, or in latch mode catches the
  rising edge and holds until cleared by a write of 1.
  Assumes the condition is already in the mclk domain.
*/
`timescale 1ns/1ps
module dis_flag_cell (
  input wire logic mclk, // register clock
  input wire logic rstn, // async reset, active low
  input wire logic cond, // source condition
  input wire logic latch_en, // 1: latch on rising edge
  input wire logic clear, // write-1 clear pulse
  output logic flag // flag value
);
  logic cond_d_reg;
  logic flag_reg;
  logic flag_next;
  logic rise;

  assign rise = cond & ~cond_d_reg;
  assign flag_next = latch_en ? (rise | (flag_reg & ~clear)) : cond;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cond_d_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      cond_d_reg <= cond;
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule // dis_flag_cell

// ==== rtl/dis_link_check.sv ====
/*
  Continuous checks of the programmed link settings.
  Assumes the configuration arrives from registers on the same clock.
*/
`timescale 1ns/1ps
module dis_link_check (
  dis_chk_if.chk chk // configuration in, check flags out
);
  import dis_pkg::*;

  logic [7:0] lane_octets;
  logic [7:0] conv_samples;
  logic [8:0] octets_needed;
  logic m_ok;
  logic l_ok;

  // two octets per sample: lanes*octets must equal 2*converters*samples
  assign lane_octets = chk.lane_count * chk.octets_per_frame;
  assign conv_samples = chk.conv_count * chk.samples_per_frame;
  assign octets_needed = {conv_samples, 1'b0};
  assign m_ok = (chk.conv_count == 4'h1) || (chk.conv_count == 4'h2);
  assign l_ok = (chk.lane_count == 4'h1) || (chk.lane_count == 4'h2) ||
                (chk.lane_count == 4'h4) || (chk.lane_count == 4'h8);

  assign chk.delay_exceeds_multiframe = chk.multiframe_clock_delay > chk.frames_per_multiframe;
  assign chk.window_limit_unsupported = chk.window_limit > WINDOW_LIMIT_MAX;
  assign chk.lane_combo_unsupported = !m_ok || !l_ok || (chk.samples_per_frame == 4'h0) ||
                                      ({1'b0, lane_octets} != octets_needed);
  assign chk.frames_per_multiframe_unsupported = (chk.frames_per_multiframe != K_SUPPORTED_A) &&
                                                 (chk.frames_per_multiframe != K_SUPPORTED_B);
endmodule // dis_link_check

// ==== rtl/dis_irq_top.sv ====
/*
  Interrupt status for the two dac channels plus the read-only link
  parameter check register, behind a simple strobe register port.
  Assumes all condition inputs come from logic clocked by mclk and a
  master that never issues read and write strobes together.
*/
// Decided for this implementation: the address-and-strobe port.
// Summary of operation
// - dac0 status bit 1 reports outside window
// - dac0 status bit 0 reports alignment tripped
// - latch mode catches rising edge, else mirror
// - latched flag clears by writing one; with latch mode off it mirrors again
// - dac1 bit 7 reports power over threshold
// - dac1 bit 3 reports alignment locked
// - dac1 bit 2 reports alignment rotated
// - dac1 bit 1 reports outside window
// - dac1 bit 0 reports alignment tripped
// - check bit 5 when delay exceeds K
// - check bit 4 on unsupported window limit
// - check bit 3 on unsupported lane combination
// - check bit 2 unless K is 16/32
`timescale 1ns/1ps
module dis_irq_top (
  input wire logic mclk, // register clock, 10 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [dis_pkg::ADDR_W-1:0] reg_addr, // register address
  input wire logic [dis_pkg::DATA_W-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [dis_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic dac0_phase_outside_window, // dac0 phase outside window
  input wire logic dac0_align_tripped, // dac0 alignment tripped
  input wire logic dac1_power_over_threshold, // dac1 data over power threshold
  input wire logic dac1_blank_finished, // dac1 blanking done
  input wire logic dac1_align_locked, // dac1 alignment locked
  input wire logic dac1_align_rotated, // dac1 clocks rotated
  input wire logic dac1_phase_outside_window, // dac1 phase outside window
  input wire logic dac1_align_tripped, // dac1 alignment tripped
  output logic irq_n // interrupt, active low
);
  import dis_pkg::*;

  dis_chk_if chk_bus ();

  // latch mode enable registers
  logic [7:0] dac0_latch_en_reg;
  logic [7:0] dac0_latch_en_next;
  logic [7:0] dac1_latch_en_reg;
  logic [7:0] dac1_latch_en_next;

  // link configuration registers
  logic [3:0] conv_count_reg;
  logic [3:0] conv_count_next;
  logic [3:0] lane_count_reg;
  logic [3:0] lane_count_next;
  logic [3:0] samples_reg;
  logic [3:0] samples_next;
  logic [3:0] octets_reg;
  logic [3:0] octets_next;
  logic [7:0] frames_per_mf_reg;
  logic [7:0] frames_per_mf_next;
  logic [7:0] mf_clock_delay_reg;
  logic [7:0] mf_clock_delay_next;
  logic [7:0] window_limit_reg;
  logic [7:0] window_limit_next;

  // read port and interrupt output
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_n_reg;
  logic irq_n_next;

  // address decode
  logic sel_dac0_latch_en;
  logic sel_dac1_latch_en;
  logic sel_dac0_status;
  logic sel_dac1_status;
  logic sel_live_cond;
  logic sel_pending;
  logic sel_checks;
  logic sel_conv_lanes;
  logic sel_samples_octets;
  logic sel_frames_per_mf;
  logic sel_mf_clock_delay;
  logic sel_window_limit;

  // flag vectors, in flag index order
  logic [FLAG_N-1:0] cond_vec;
  logic [FLAG_N-1:0] latch_vec;
  logic [FLAG_N-1:0] clear_vec;
  logic [FLAG_N-1:0] flag_vec;
  logic [FLAG_N-1:0] pending_vec;

  // read views
  logic [7:0] dac0_status;
  logic [7:0] dac1_status;
  logic [7:0] checks;
  logic [7:0] read_mux;
  logic wr_dac0_status;
  logic wr_dac1_status;

  assign sel_dac0_latch_en = (reg_addr == OFS_DAC0_LATCH_EN);
  assign sel_dac1_latch_en = (reg_addr == OFS_DAC1_LATCH_EN);
  assign sel_dac0_status = (reg_addr == OFS_DAC0_STATUS);
  assign sel_dac1_status = (reg_addr == OFS_DAC1_STATUS);
  assign sel_live_cond = (reg_addr == OFS_LIVE_COND);
  assign sel_pending = (reg_addr == OFS_PENDING);
  assign sel_checks = (reg_addr == OFS_CHECKS);
  assign sel_conv_lanes = (reg_addr == OFS_CONV_LANES);
  assign sel_samples_octets = (reg_addr == OFS_SAMPLES_OCTETS);
  assign sel_frames_per_mf = (reg_addr == OFS_FRAMES_PER_MF);
  assign sel_mf_clock_delay = (reg_addr == OFS_MF_CLOCK_DELAY);
  assign sel_window_limit = (reg_addr == OFS_WINDOW_LIMIT);

  assign wr_dac0_status = reg_wr && sel_dac0_status;
  assign wr_dac1_status = reg_wr && sel_dac1_status;

  // gather the source conditions
  assign cond_vec[FLG_DAC0_TRIP] = dac0_align_tripped;
  assign cond_vec[FLG_DAC0_WINDOW] = dac0_phase_outside_window;
  assign cond_vec[FLG_DAC1_TRIP] = dac1_align_tripped;
  assign cond_vec[FLG_DAC1_WINDOW] = dac1_phase_outside_window;
  assign cond_vec[FLG_DAC1_ROTATE] = dac1_align_rotated;
  assign cond_vec[FLG_DAC1_LOCK] = dac1_align_locked;
  assign cond_vec[FLG_DAC1_BLANK] = dac1_blank_finished;
  assign cond_vec[FLG_DAC1_POWER] = dac1_power_over_threshold;

  // latch mode enables share the status register layout
  assign latch_vec[FLG_DAC0_TRIP] = dac0_latch_en_reg[D0_TRIP_BIT];
  assign latch_vec[FLG_DAC0_WINDOW] = dac0_latch_en_reg[D0_WINDOW_BIT];
  assign latch_vec[FLG_DAC1_TRIP] = dac1_latch_en_reg[D1_TRIP_BIT];
  assign latch_vec[FLG_DAC1_WINDOW] = dac1_latch_en_reg[D1_WINDOW_BIT];
  assign latch_vec[FLG_DAC1_ROTATE] = dac1_latch_en_reg[D1_ROTATE_BIT];
  assign latch_vec[FLG_DAC1_LOCK] = dac1_latch_en_reg[D1_LOCK_BIT];
  assign latch_vec[FLG_DAC1_BLANK] = dac1_latch_en_reg[D1_BLANK_BIT];
  assign latch_vec[FLG_DAC1_POWER] = dac1_latch_en_reg[D1_POWER_BIT];

  // write one clears that bit only
  assign clear_vec[FLG_DAC0_TRIP] = wr_dac0_status && reg_wdata[D0_TRIP_BIT];
  assign clear_vec[FLG_DAC0_WINDOW] = wr_dac0_status && reg_wdata[D0_WINDOW_BIT];
  assign clear_vec[FLG_DAC1_TRIP] = wr_dac1_status && reg_wdata[D1_TRIP_BIT];
  assign clear_vec[FLG_DAC1_WINDOW] = wr_dac1_status && reg_wdata[D1_WINDOW_BIT];
  assign clear_vec[FLG_DAC1_ROTATE] = wr_dac1_status && reg_wdata[D1_ROTATE_BIT];
  assign clear_vec[FLG_DAC1_LOCK] = wr_dac1_status && reg_wdata[D1_LOCK_BIT];
  assign clear_vec[FLG_DAC1_BLANK] = wr_dac1_status && reg_wdata[D1_BLANK_BIT];
  assign clear_vec[FLG_DAC1_POWER] = wr_dac1_status && reg_wdata[D1_POWER_BIT];

  for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
    dis_flag_cell u_cell (
      .mclk(mclk),
      .rstn(rstn),
      .cond(cond_vec[i]),
      .latch_en(latch_vec[i]),
      .clear(clear_vec[i]),
      .flag(flag_vec[i])
    );
  end

  // mirrored flags never interrupt; only latched ones do
  assign pending_vec = flag_vec & latch_vec;

  assign dac0_status[7:2] = 6'h00;
  assign dac0_status[D0_WINDOW_BIT] = flag_vec[FLG_DAC0_WINDOW];
  assign dac0_status[D0_TRIP_BIT] = flag_vec[FLG_DAC0_TRIP];

  assign dac1_status[D1_POWER_BIT] = flag_vec[FLG_DAC1_POWER];
  assign dac1_status[6] = 1'b0;
  assign dac1_status[4] = 1'b0;
  assign dac1_status[D1_BLANK_BIT] = flag_vec[FLG_DAC1_BLANK];
  assign dac1_status[D1_LOCK_BIT] = flag_vec[FLG_DAC1_LOCK];
  assign dac1_status[D1_ROTATE_BIT] = flag_vec[FLG_DAC1_ROTATE];
  assign dac1_status[D1_WINDOW_BIT] = flag_vec[FLG_DAC1_WINDOW];
  assign dac1_status[D1_TRIP_BIT] = flag_vec[FLG_DAC1_TRIP];

  // configuration out to the checker
  assign chk_bus.conv_count = conv_count_reg;
  assign chk_bus.lane_count = lane_count_reg;
  assign chk_bus.samples_per_frame = samples_reg;
  assign chk_bus.octets_per_frame = octets_reg;
  assign chk_bus.frames_per_multiframe = frames_per_mf_reg;
  assign chk_bus.multiframe_clock_delay = mf_clock_delay_reg;
  assign chk_bus.window_limit = window_limit_reg;

  dis_link_check u_check (
    .chk(chk_bus.chk)
  );

  // check bits 7:6 and 1:0 read zero
  assign checks = {2'b00,
                   chk_bus.delay_exceeds_multiframe,
                   chk_bus.window_limit_unsupported,
                   chk_bus.lane_combo_unsupported,
                   chk_bus.frames_per_multiframe_unsupported,
                   2'b00};

  // register writes; status and check offsets take no data
  assign dac0_latch_en_next = (reg_wr && sel_dac0_latch_en) ?
                              (reg_wdata & 8'h03) : dac0_latch_en_reg;
  assign dac1_latch_en_next = (reg_wr && sel_dac1_latch_en) ?
                              (reg_wdata & 8'hAF) : dac1_latch_en_reg;
  assign conv_count_next = (reg_wr && sel_conv_lanes) ? reg_wdata[3:0] : conv_count_reg;
  assign lane_count_next = (reg_wr && sel_conv_lanes) ? reg_wdata[7:4] : lane_count_reg;
  assign samples_next = (reg_wr && sel_samples_octets) ? reg_wdata[3:0] : samples_reg;
  assign octets_next = (reg_wr && sel_samples_octets) ? reg_wdata[7:4] : octets_reg;
  assign frames_per_mf_next = (reg_wr && sel_frames_per_mf) ? reg_wdata : frames_per_mf_reg;
  assign mf_clock_delay_next = (reg_wr && sel_mf_clock_delay) ? reg_wdata : mf_clock_delay_reg;
  assign window_limit_next = (reg_wr && sel_window_limit) ? reg_wdata : window_limit_reg;

  // read mux; unmapped offsets read zero
  assign read_mux = sel_dac0_latch_en ? dac0_latch_en_reg :
                    sel_dac1_latch_en ? dac1_latch_en_reg :
                    sel_dac0_status ? dac0_status :
                    sel_dac1_status ? dac1_status :
                    sel_live_cond ? cond_vec :
                    sel_pending ? pending_vec :
                    sel_checks ? checks :
                    sel_conv_lanes ? {lane_count_reg, conv_count_reg} :
                    sel_samples_octets ? {octets_reg, samples_reg} :
                    sel_frames_per_mf ? frames_per_mf_reg :
                    sel_mf_clock_delay ? mf_clock_delay_reg :
                    sel_window_limit ? window_limit_reg :
                    8'h00;

  // data stand only in the cycle after the strobe
  assign rdata_next = reg_rd ? read_mux : 8'h00;

  // low while enabled latched flag set
  assign irq_n_next = ~(|pending_vec);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dac0_latch_en_reg <= RST_LATCH_EN;
      dac1_latch_en_reg <= RST_LATCH_EN;
    end else begin
      dac0_latch_en_reg <= dac0_latch_en_next;
      dac1_latch_en_reg <= dac1_latch_en_next;
    end
  end

  // config resets to a supported setting so checks start clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conv_count_reg <= RST_CONV_COUNT;
      lane_count_reg <= RST_LANE_COUNT;
      samples_reg <= RST_SAMPLES;
      octets_reg <= RST_OCTETS;
    end else begin
      conv_count_reg <= conv_count_next;
      lane_count_reg <= lane_count_next;
      samples_reg <= samples_next;
      octets_reg <= octets_next;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      frames_per_mf_reg <= RST_FRAMES_PER_MF;
      mf_clock_delay_reg <= RST_MF_CLOCK_DELAY;
      window_limit_reg <= RST_WINDOW_LIMIT;
    end else begin
      frames_per_mf_reg <= frames_per_mf_next;
      mf_clock_delay_reg <= mf_clock_delay_next;
      window_limit_reg <= window_limit_next;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= RST_STATUS;
      irq_n_reg <= 1'b1;
    end else begin
      rdata_reg <= rdata_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq_n = irq_n_reg;
endmodule // dis_irq_top

// ==== verification/dis_irq_asserts.sv ====
/*
  Concurrent checks on the ports of dis_irq_top: read data timing,
  reserved bits and the causes of interrupt edges.
  Assumes one clock, mclk, and the active-low reset rstn.
*/
`timescale 1ns/1ps
module dis_irq_asserts (
  input wire logic mclk, // register clock
  input wire logic rstn, // reset, active low
  input wire logic [dis_pkg::ADDR_W-1:0] reg_addr, // address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [dis_pkg::DATA_W-1:0] reg_rdata, // read data
  input wire logic dac0_phase_outside_window, // condition
  input wire logic dac0_align_tripped, // condition
  input wire logic dac1_power_over_threshold, // condition
  input wire logic dac1_blank_finished, // condition
  input wire logic dac1_align_locked, // condition
  input wire logic dac1_align_rotated, // condition
  input wire logic dac1_phase_outside_window, // condition
  input wire logic dac1_align_tripped, // condition
  input wire logic irq_n // interrupt, active low
);
  import dis_pkg::*;
  logic [7:0] cond;
  logic lat_wr;
  assign cond = {dac1_power_over_threshold, dac1_blank_finished, dac1_align_locked, dac1_align_rotated,
    dac1_phase_outside_window, dac1_align_tripped, dac0_phase_outside_window, dac0_align_tripped};
  // enabling latch mode on a set mirrored flag may also pull the line
  assign lat_wr = reg_wr && (reg_addr == OFS_DAC0_LATCH_EN || reg_addr == OFS_DAC1_LATCH_EN);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_chk_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_CHECKS |-> reg_rdata[7:6] == 2'b00)
    else $error("check register reserved bits set");
  a_d1_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_DAC1_STATUS
    |-> reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0)
    else $error("dac1 status reserved bits set");
  a_d0_reserved_zero: assert property ($past(reg_rd) && $past(reg_addr) == OFS_DAC0_STATUS
    |-> reg_rdata[7:2] == 6'h00)
    else $error("dac0 status unused bits set");
  a_en_mask_dac0: assert property ($past(reg_rd) && $past(reg_addr) == OFS_DAC0_LATCH_EN
    |-> reg_rdata[7:2] == 6'h00)
    else $error("dac0 latch enable unused bits set");
  a_en_mask_dac1: assert property ($past(reg_rd) && $past(reg_addr) == OFS_DAC1_LATCH_EN
    |-> reg_rdata[6] == 1'b0 && reg_rdata[4] == 1'b0)
    else $error("dac1 latch enable unused bits set");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 12'h0ff |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_fall_cause: assert property ($fell(irq_n)
    |-> (($past(cond, 2) & ~$past(cond, 3)) != 8'h00) || $past(lat_wr) || $past(lat_wr, 2))
    else $error("interrupt asserted without a rising condition");
  a_irq_rise_cause: assert property ($rose(irq_n) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt released without a write");
endmodule // dis_irq_asserts

bind dis_irq_top dis_irq_asserts u_asserts (
  .mclk(mclk),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .dac0_phase_outside_window(dac0_phase_outside_window),
  .dac0_align_tripped(dac0_align_tripped),
  .dac1_power_over_threshold(dac1_power_over_threshold),
  .dac1_blank_finished(dac1_blank_finished),
  .dac1_align_locked(dac1_align_locked),
  .dac1_align_rotated(dac1_align_rotated),
  .dac1_phase_outside_window(dac1_phase_outside_window),
  .dac1_align_tripped(dac1_align_tripped),
  .irq_n(irq_n)
);

// ==== verification/testbench.sv ====
/*
  Self-checking bench for dis_irq_top: reset values, mirrored and
  latched flags, write-1 clear, interrupt line and link checks.
  Assumes a 10 MHz mclk; random stimulus from a fixed seed.
*/
`timescale 1ns/1ps
module testbench;
  import dis_pkg::*;
  logic mclk, rstn, reg_wr, reg_rd, irq_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [7:0] cond, v, ml, sf, k, d, w;
  int fails, num_checks, seed, i, j;

  dis_irq_top dut (
    .mclk(mclk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dac0_phase_outside_window(cond[1]),
    .dac0_align_tripped(cond[0]),
    .dac1_power_over_threshold(cond[7]),
    .dac1_blank_finished(cond[6]),
    .dac1_align_locked(cond[5]),
    .dac1_align_rotated(cond[4]),
    .dac1_phase_outside_window(cond[3]),
    .dac1_align_tripped(cond[2]),
    .irq_n(irq_n)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic conclude;
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] dt);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dt;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    cmp8(reg_rdata, exp, what);
  endtask

  task automatic setc(input logic [7:0] c, input int n);
    @(posedge mclk);
    cond <= c;
    repeat (n) @(posedge mclk);
  endtask

  function automatic logic [7:0] d0v(input logic [7:0] f);
    return {6'h00, f[1:0]};
  endfunction

  function automatic logic [7:0] d1v(input logic [7:0] f);
    return {f[7], 1'b0, f[6], 1'b0, f[5:2]};
  endfunction

  function automatic logic [7:0] chk(input logic [7:0] ml, sf, k, d, w);
    int mm, ll, ss, ff;
    logic ok;
    mm = ml[3:0];
    ll = ml[7:4];
    ss = sf[3:0];
    ff = sf[7:4];
    ok = (mm == 1 || mm == 2) && (ll inside {1, 2, 4, 8}) && ss != 0 && ll * ff == 2 * mm * ss;
    return {2'b00, d > k, w > 8'h03, !ok, !(k == 8'h10 || k == 8'h20), 2'b00};
  endfunction

  initial begin
    #1_000_000;
    fails++;
    conclude();
  end

  initial begin
    seed = 77262;
    fails = 0;
    num_checks = 0;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    cond = 8'h00;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    cmp1(irq_n, 1'b1, "irq after reset");
    rd(OFS_DAC1_STATUS, 8'h00, "dac1 reset");
    rd(OFS_DAC0_STATUS, 8'h00, "dac0 reset");
    rd(OFS_CHECKS, 8'h00, "checks reset");
    rd(12'h0ff, 8'h00, "unmapped read");
    for (i = 0; i < 12; i++) begin
      v = 8'($random(seed));
      setc(v, 2);
      wr(OFS_DAC1_STATUS, 8'hff);
      rd(OFS_LIVE_COND, v, "live conditions");
      rd(OFS_PENDING, 8'h00, "pending in mirror mode");
      rd(OFS_DAC0_STATUS, d0v(v), "dac0 mirror");
      rd(OFS_DAC1_STATUS, d1v(v), "dac1 mirror");
      cmp1(irq_n, 1'b1, "irq in mirror mode");
    end
    setc(8'h00, 2);
    wr(OFS_DAC0_LATCH_EN, 8'hff);
    wr(OFS_DAC1_LATCH_EN, 8'hff);
    rd(OFS_DAC0_LATCH_EN, 8'h03, "dac0 latch enable");
    rd(OFS_DAC1_LATCH_EN, 8'haf, "dac1 latch enable");
    // two flags at once, so a clear that hits a neighbour shows
    for (i = 0; i < 8; i++) begin
      j = (i + 1) % 8;
      v = (8'h01 << i) | (8'h01 << j);
      setc(v, 1);
      setc(8'h00, 3);
      cmp1(irq_n, 1'b0, "irq on latch");
      rd(OFS_PENDING, v, "pending latched");
      rd(OFS_DAC0_STATUS, d0v(v), "dac0 latched");
      rd(OFS_DAC1_STATUS, d1v(v), "dac1 latched");
      wr(OFS_DAC0_STATUS, d0v(8'h01 << i));
      wr(OFS_DAC1_STATUS, d1v(8'h01 << i));
      v = 8'h01 << j;
      rd(OFS_DAC0_STATUS, d0v(v), "dac0 one cleared");
      rd(OFS_DAC1_STATUS, d1v(v), "dac1 one cleared");
      cmp1(irq_n, 1'b0, "irq held by other flag");
      wr(OFS_DAC0_STATUS, d0v(v));
      wr(OFS_DAC1_STATUS, d1v(v));
      repeat (2) @(posedge mclk);
      #1;
      cmp1(irq_n, 1'b1, "irq released");
    end
    // clear and a new rising edge in one cycle: the set must win
    fork
      wr(OFS_DAC0_STATUS, 8'h01);
      setc(8'h01, 1);
    join
    rd(OFS_DAC0_STATUS, 8'h01, "set wins over clear");
    setc(8'h00, 1);
    wr(OFS_DAC0_STATUS, 8'h01);
    rd(OFS_DAC0_STATUS, 8'h00, "cleared after set");
    for (i = 0; i < 24; i++) begin
      ml = 8'($random(seed));
      sf = 8'($random(seed));
      k = 8'($random(seed));
      d = 8'($random(seed));
      w = 8'($random(seed));
      if (i < 6) begin
        ml = 8'h42;
        sf = 8'h11;
        k = i[0] ? 8'h20 : 8'h10;
        d = k + {6'h00, i[2:1]} - 8'h01;
        w = {6'h00, i[1:0]} + 8'h02;
      end
      wr(OFS_CONV_LANES, ml);
      wr(OFS_SAMPLES_OCTETS, sf);
      wr(OFS_FRAMES_PER_MF, k);
      wr(OFS_MF_CLOCK_DELAY, d);
      wr(OFS_WINDOW_LIMIT, w);
      wr(OFS_CHECKS, 8'hff);
      rd(OFS_CHECKS, chk(ml, sf, k, d, w), "link checks");
    end
    conclude();
  end
endmodule // testbench
